// ### vlm_pkg.sv
/*
  Shared constants and carriers for the virtual list maintenance block.
  Assumes one clock domain and system register requests from the core.
*/
package vlm_pkg;
  // System register encoding
  localparam logic [2:0] OP1_HYP    = 3'h4;
  localparam logic [3:0] CRN_HYP    = 4'hc;
  localparam logic [3:0] CRM_CTL    = 4'hb;
  localparam logic [2:0] OP2_STATUS = 3'h2;
  localparam logic [2:0] CRM_LR_TOP = 3'h6;
  localparam logic [1:0] EL_HYP     = 2'h2;
  localparam logic [1:0] EL_TOP     = 2'h3;
  // Entry field positions
  localparam int ST_HI  = 63;
  localparam int ST_LO  = 62;
  localparam int HW_BIT = 61;
  localparam int GRP_BIT = 60;
  localparam int PR_HI  = 55;
  localparam int PR_LO  = 48;
  localparam int PID_HI = 41;
  localparam int PID_LO = 32;
  localparam int EOI_BIT = 41;
  localparam int VID_HI = 31;
  // Entry states
  localparam logic [1:0] ST_INACT = 2'h0;
  localparam logic [1:0] ST_PEND  = 2'h1;
  localparam logic [1:0] ST_ACT   = 2'h2;
  localparam logic [1:0] ST_PA    = 2'h3;
  // Status bit positions
  localparam int MS_EOI = 0;
  localparam int MS_U   = 1;
  localparam int MS_MISS   = 2;
  localparam int MS_NOPEND = 3;
  localparam int MS_G0E = 4;
  localparam int MS_G0D = 5;
  localparam int MS_G1E = 6;
  localparam int MS_G1D = 7;
  // Per-processor identifier range and width codes
  localparam logic [9:0]  PCPU_LO = 10'h010;
  localparam logic [9:0]  PCPU_HI = 10'h01f;
  localparam logic [2:0]  IDW_16  = 3'h0;
  localparam logic [2:0]  IDW_24  = 3'h1;
  localparam logic [63:0] LR_RST  = 64'h0;
  localparam logic [31:0] MS_RST  = 32'h0;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  el;
    logic [2:0]  op1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  op2;
    logic [63:0] wdata;
  } vlm_req_s;

  typedef struct packed {
    logic        done;
    logic        trap;
    logic [63:0] rdata;
  } vlm_rsp_s;

  typedef struct packed {
    logic       en;
    logic       g1_off_irq_on;
    logic       g1_on_irq_on;
    logic       g0_off_irq_on;
    logic       g0_on_irq_on;
    logic       no_pending_irq_on;
    logic       missing_entry_irq_on;
    logic       low_entry_irq_on;
    logic [4:0] unmatched_end_tally;
  } vlm_hyp_s;

  typedef struct packed {
    logic vm_grp1_on;
    logic vm_grp0_on;
  } vlm_vm_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] idx;
  } vlm_evt_s;

  typedef struct packed {
    logic       valid;
    logic       per_cpu_irq;
    logic [7:0] pe;
    logic [9:0] physical_int_id;
  } vlm_deact_s;
endpackage : vlm_pkg

// ### vlm_top.sv
/*
  List register entries and maintenance status for a virtual CPU interface.
  Assumes requests and lifecycle events synchronous to mclk, one per cycle.
*/
// Behaviour
// - At least five priority bits, low bits zero
// - Reset clears entries and status to zero
// - Unlinked entry bit 41 notifies on deactivation
// - Linked entry holds physical id, upper zero
// - Only ten physical id bits are kept
// - Ids 16-31 target this processor's interrupt
// - At least 16 virtual id bits, rest zero
// - Entry n selected by CRm and op2
// - Trap accesses when interface enable is off
// - Group 1 disabled flag in bit 7
// - Group 1 enabled flag in bit 6
// - Group 0 disabled flag in bit 5
// - Group 0 enabled flag in bit 4
// - No pending flag in bit 3
// - Entry missing flag in bit 2
// - Underflow flag in bit 1
// - End of interrupt flag in bit 0
// - End of interrupt flag uses entry contents only
// - Status read-only, op2 010, upper zero
// - Two-bit state updated through lifecycle
// - Linked deactivation sends physical id request
// - No maintenance interrupt while disabled
`timescale 1ns/1ps
module vlm_top #(
  parameter int         NUM_LR   = 16,
  parameter int         PRI_BITS = 5,
  parameter int         ID_BITS  = 16,
  parameter logic [7:0] PE_ID    = 8'h00
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  vlm_pkg::vlm_req_s  req,
  input  vlm_pkg::vlm_hyp_s  hyp_control,
  input  vlm_pkg::vlm_vm_s   vm_control,
  input  wire logic          sysreg_iface_on_hyp,
  input  wire logic          sysreg_iface_on_top,
  input  vlm_pkg::vlm_evt_s  ack_evt,
  input  vlm_pkg::vlm_evt_s  deact_evt,
  output vlm_pkg::vlm_rsp_s  rsp,
  output vlm_pkg::vlm_deact_s deact_req,
  output logic [31:0]        maintenance_status,
  output logic               maint_irq,
  output logic [2:0]         prio_width_field,
  output logic [2:0]         id_width_field
);
  import vlm_pkg::*;

  localparam logic [7:0]  PRIO_MASK = 8'(8'hff << (8 - PRI_BITS));
  localparam logic [31:0] VID_MASK  = 32'((64'h1 << ID_BITS) - 64'h1);

  logic [63:0]       lr [NUM_LR];
  logic [NUM_LR-1:0] pend_v;
  logic [NUM_LR-1:0] valid_v;
  logic [NUM_LR-1:0] end_of_int_summary;
  logic              acc_hit;
  logic              acc_ok;
  logic              lr_sel;
  logic              st_sel;
  logic [3:0]        idx;
  logic [7:0]        next_flags;
  logic [63:0]       next_rdata;

  // Entry n lives at CRm 110:n<3>, op2 n<2:0>
  function automatic logic is_lr(input vlm_req_s r);
    is_lr = r.crm[3:1] == CRM_LR_TOP && 32'({r.crm[0], r.op2}) < NUM_LR;
  endfunction : is_lr

  function automatic logic [3:0] lr_idx(input vlm_req_s r);
    lr_idx = {r.crm[0], r.op2};
  endfunction : lr_idx

  // Stores only implemented bits; reserved fields drop to zero
  function automatic logic [63:0] clean(input logic [63:0] w);
    clean = LR_RST;
    clean[ST_HI:GRP_BIT] = w[ST_HI:GRP_BIT];
    clean[PR_HI:PR_LO] = w[PR_HI:PR_LO] & PRIO_MASK;
    clean[VID_HI:0] = w[VID_HI:0] & VID_MASK;
    if (w[HW_BIT])
      clean[PID_HI:PID_LO] = w[PID_HI:PID_LO];
    else
      clean[EOI_BIT] = w[EOI_BIT];
  endfunction : clean

  // Access decode and permission check
  always_comb
  begin
    idx    = lr_idx(req);
    lr_sel = is_lr(req);
    st_sel = req.crm == CRM_CTL && req.op2 == OP2_STATUS;
    acc_hit = req.valid && req.op1 == OP1_HYP && req.crn == CRN_HYP
              && (lr_sel || st_sel);
    acc_ok = (req.el == EL_HYP && sysreg_iface_on_hyp)
             || (req.el == EL_TOP && sysreg_iface_on_top);
  end

  // Per-entry storage and lifecycle state
  for (genvar i = 0; i < NUM_LR; i++)
  begin : g_lr
    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
        lr[i] <= LR_RST;
      else if (acc_hit && acc_ok && lr_sel && req.write && idx == 4'(i))
        lr[i] <= clean(req.wdata);
      else if (ack_evt.valid && ack_evt.idx == 4'(i)
               && lr[i][ST_HI:ST_LO] == ST_PEND)
        lr[i][ST_HI:ST_LO] <= ST_ACT;
      else if (deact_evt.valid && deact_evt.idx == 4'(i) && lr[i][ST_HI])
        lr[i][ST_HI:ST_LO] <= {1'b0, lr[i][ST_LO]};
    end

    // Entry summaries; only entry contents count
    assign pend_v[i]  = lr[i][ST_LO];
    assign valid_v[i] = lr[i][ST_HI:ST_LO] != ST_INACT;
    assign end_of_int_summary[i] = lr[i][ST_HI:ST_LO] == ST_INACT
                                   && !lr[i][HW_BIT] && lr[i][EOI_BIT];

    a_prio_low_zero: assert property (@(posedge mclk) disable iff (!rst_b)
      (lr[i][PR_HI:PR_LO] & ~PRIO_MASK) == 8'h00)
      else $error("unimplemented priority bits set");
    a_unlinked_resv: assert property (@(posedge mclk) disable iff (!rst_b)
      !lr[i][HW_BIT] |-> lr[i][EOI_BIT-1:PID_LO] == 9'h000)
      else $error("reserved physical id bits set");
  end

  // Maintenance flags, bit 7 down to bit 0
  always_comb
  begin
    next_flags[MS_G1D] = hyp_control.g1_off_irq_on && !vm_control.vm_grp1_on;
    next_flags[MS_G1E] = hyp_control.g1_on_irq_on && vm_control.vm_grp1_on;
    next_flags[MS_G0D] = hyp_control.g0_off_irq_on && !vm_control.vm_grp0_on;
    next_flags[MS_G0E] = hyp_control.g0_on_irq_on && vm_control.vm_grp0_on;
    next_flags[MS_NOPEND] = hyp_control.no_pending_irq_on && pend_v == '0;
    next_flags[MS_MISS] = hyp_control.missing_entry_irq_on
                           && hyp_control.unmatched_end_tally != 5'h00;
    next_flags[MS_U] = hyp_control.low_entry_irq_on
                       && (valid_v & (valid_v - 1'b1)) == '0;
    next_flags[MS_EOI] = |end_of_int_summary;
  end

  // Status register and interrupt output
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      maintenance_status <= MS_RST;
      maint_irq          <= 1'b0;
    end
    else
    begin
      maintenance_status <= {24'h000000, next_flags};
      maint_irq          <= hyp_control.en && |next_flags;
    end
  end

  // Read data select; status is read-only
  always_comb
  begin
    next_rdata = 64'h0;
    if (lr_sel)
      next_rdata = lr[idx];
    else if (st_sel)
      next_rdata = {32'h0, maintenance_status};
  end

  // Register access response, one cycle after the request
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rsp <= '0;
    else
    begin
      rsp.done  <= req.valid;
      rsp.trap  <= acc_hit && !acc_ok;
      rsp.rdata <= (acc_hit && acc_ok && !req.write) ? next_rdata : 64'h0;
    end
  end

  // Deactivate request for hardware-linked entries
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      deact_req <= '0;
    else if (deact_evt.valid && 32'(deact_evt.idx) < NUM_LR
             && lr[deact_evt.idx][ST_HI] && lr[deact_evt.idx][HW_BIT])
    begin
      deact_req.valid <= 1'b1;
      deact_req.physical_int_id <= lr[deact_evt.idx][PID_HI:PID_LO];
      deact_req.per_cpu_irq <= lr[deact_evt.idx][PID_HI:PID_LO] >= PCPU_LO
                               && lr[deact_evt.idx][PID_HI:PID_LO] <= PCPU_HI;
      deact_req.pe <= PE_ID;
    end
    else
      deact_req.valid <= 1'b0;
  end

  // Implemented width reporting
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prio_width_field <= 3'h0;
      id_width_field   <= IDW_16;
    end
    else
    begin
      prio_width_field <= 3'(PRI_BITS - 1);
      id_width_field   <= (ID_BITS >= 24) ? IDW_24 : IDW_16;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_grp1_off: assert property (hyp_control.g1_off_irq_on && !vm_control.vm_grp1_on
    |=> maintenance_status[MS_G1D])
    else $error("group 1 disabled flag missing");
  a_grp1_on: assert property (hyp_control.g1_on_irq_on && vm_control.vm_grp1_on
    |=> maintenance_status[MS_G1E])
    else $error("group 1 enabled flag missing");
  a_grp0_off: assert property (!hyp_control.g0_off_irq_on
    |=> !maintenance_status[MS_G0D])
    else $error("group 0 disabled flag without enable");
  a_grp0_on: assert property (hyp_control.g0_on_irq_on && vm_control.vm_grp0_on
    |=> maintenance_status[MS_G0E])
    else $error("group 0 enabled flag missing");
  a_no_pend: assert property (hyp_control.no_pending_irq_on && pend_v == '0
    |=> maintenance_status[MS_NOPEND])
    else $error("no pending flag missing");
  a_entry_miss: assert property (hyp_control.missing_entry_irq_on
    && hyp_control.unmatched_end_tally != 5'h00 |=> maintenance_status[MS_MISS])
    else $error("entry missing flag missing");
  a_underflow_on: assert property ($countones(valid_v) >= 2 |=> !maintenance_status[MS_U])
    else $error("underflow with two valid entries");
  a_eoi_flag: assert property (|end_of_int_summary |=> maintenance_status[MS_EOI])
    else $error("end of interrupt flag missing");
  a_status_resv: assert property (maintenance_status[31:8] == 24'h000000)
    else $error("status reserved bits set");
  a_irq_gate: assert property (!hyp_control.en |=> !maint_irq)
    else $error("interrupt while interface disabled");
  a_irq_or: assert property (maint_irq |-> $past(hyp_control.en)
    && maintenance_status[7:0] != 8'h00)
    else $error("interrupt without flag");
  a_trap_hyp: assert property (acc_hit && req.el == EL_HYP && !sysreg_iface_on_hyp
    |=> rsp.trap && rsp.rdata == 64'h0)
    else $error("access not trapped");
  a_deact_fwd: assert property (deact_evt.valid && lr[deact_evt.idx][ST_HI]
    && lr[deact_evt.idx][HW_BIT] |=> deact_req.valid
    && deact_req.physical_int_id == $past(lr[deact_evt.idx][PID_HI:PID_LO]))
    else $error("deactivate request missing");
  a_ack_state: assert property (ack_evt.valid && lr[ack_evt.idx][ST_HI:ST_LO] == ST_PEND
    && !(acc_hit && req.write) |=> lr[$past(ack_evt.idx)][ST_HI:ST_LO] == ST_ACT)
    else $error("acknowledge did not activate");

  // Positive and negative sides of the flag equations
  a_grp0_off_set: assert property (hyp_control.g0_off_irq_on && !vm_control.vm_grp0_on
    |=> maintenance_status[MS_G0D])
    else $error("group 0 disabled flag missing");
  a_underflow_set: assert property (hyp_control.low_entry_irq_on && $countones(valid_v) <= 1
    |=> maintenance_status[MS_U])
    else $error("underflow flag missing");
  a_no_pend_clr: assert property (pend_v != '0 |=> !maintenance_status[MS_NOPEND])
    else $error("no pending flag with pending entry");
  a_eoi_clear: assert property (end_of_int_summary == '0 |=> !maintenance_status[MS_EOI])
    else $error("end of interrupt flag without summary bit");
  a_irq_set: assert property (hyp_control.en && next_flags != 8'h00 |=> maint_irq)
    else $error("interrupt missing with flag set");

  // Access path: every request answered, trap from the top level, writes land
  a_done_pulse: assert property (req.valid |=> rsp.done)
    else $error("request not answered");
  a_trap_top: assert property (acc_hit && req.el == EL_TOP && !sysreg_iface_on_top
    |=> rsp.trap)
    else $error("top level access not trapped");
  a_lr_write: assert property (acc_hit && acc_ok && lr_sel && req.write
    |=> lr[$past(idx)] == $past(clean(req.wdata)))
    else $error("entry write lost");

  // Lifecycle and deactivation side effects
  a_deact_state: assert property (deact_evt.valid && lr[deact_evt.idx][ST_HI]
    && !(acc_hit && req.write) |=> !lr[$past(deact_evt.idx)][ST_HI])
    else $error("deactivation left entry active");
  a_deact_quiet: assert property (deact_evt.valid && !lr[deact_evt.idx][HW_BIT]
    |=> !deact_req.valid)
    else $error("deactivate request for unlinked entry");
  a_deact_pe: assert property (deact_req.valid |-> deact_req.pe == PE_ID)
    else $error("deactivate request for wrong processor");

  // Width fields load on the first edge after reset
  a_width_rep: assert property (1'b1 |=> prio_width_field == 3'(PRI_BITS - 1))
    else $error("priority width field wrong");

  c_underflow: cover property (maintenance_status[MS_U]);
  c_ack_deact: cover property (ack_evt.valid ##1 deact_evt.valid);
  c_ppi_deact: cover property (deact_req.valid && deact_req.per_cpu_irq);
  c_irq: cover property (maint_irq);
  c_trap: cover property (rsp.trap);
endmodule : vlm_top

// ### tb.sv
/*
  Self-checking bench for vlm_top: entries, traps, status flags, lifecycle.
  Assumes vlm_pkg is compiled first and default parameters on the design.
*/
`timescale 1ns/1ps
module tb;
  import vlm_pkg::*;
  logic        mclk;
  logic        rst_b;
  vlm_req_s    req;
  vlm_hyp_s    hyp;
  vlm_vm_s     vm;
  logic        on_hyp;
  logic        on_top;
  vlm_evt_s    ack_evt;
  vlm_evt_s    deact_evt;
  vlm_rsp_s    rsp;
  vlm_deact_s  dq;
  logic [31:0] status;
  logic        irq;
  logic [2:0]  pw;
  logic [2:0]  iw;
  logic [63:0] rd;
  int          failures;
  int          n_compared;

  vlm_top u_vlm_top (.mclk(mclk), .rst_b(rst_b), .req(req), .hyp_control(hyp), .vm_control(vm),
    .sysreg_iface_on_hyp(on_hyp), .sysreg_iface_on_top(on_top), .ack_evt(ack_evt),
    .deact_evt(deact_evt), .rsp(rsp), .deact_req(dq), .maintenance_status(status),
    .maint_irq(irq), .prio_width_field(pw), .id_width_field(iw));

  // Clock, 4 ns period
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask : check

  // One request, answered one cycle after it is taken
  task automatic acc(logic wr, logic [1:0] el, logic [3:0] crm, logic [2:0] op2, logic [63:0] wd,
                     logic exp_trap);
    @(posedge mclk);
    req <= '{1'b1, wr, el, OP1_HYP, CRN_HYP, crm, op2, wd};
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    check("done", rsp.done, 1'b1);
    check("trap", rsp.trap, exp_trap);
    rd = rsp.rdata;
  endtask : acc

  task automatic lr(logic wr, logic [3:0] n, logic [63:0] wd);
    acc(wr, EL_HYP, {CRM_LR_TOP, n[3]}, n[2:0], wd, 1'b0);
  endtask : lr

  // Inputs land, status registers them, then sample
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task automatic evt(logic is_ack, logic [3:0] idx);
    @(posedge mclk);
    if (is_ack)
      ack_evt <= '{1'b1, idx};
    else
      deact_evt <= '{1'b1, idx};
    @(posedge mclk);
    ack_evt.valid <= 1'b0;
    deact_evt.valid <= 1'b0;
    #1;
  endtask : evt

  task automatic t_reset();
    settle();
    check("status", status, 64'h0);
    check("pw", pw, 64'h4);
    check("iw", iw, IDW_16);
    lr(1'b0, 4'hf, 64'h0);
    check("lr15", rd, 64'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_fields();
    lr(1'b1, 4'hf, '1);
    lr(1'b1, 4'h9, 64'hdfff_ffff_ffff_ffff);
    lr(1'b0, 4'hf, 64'h0);
    check("lr15", rd, 64'hf0f8_03ff_0000_ffff);
    lr(1'b0, 4'h9, 64'h0);
    check("lr9", rd, 64'hd0f8_0200_0000_ffff);
    lr(1'b1, 4'hf, 64'h0);
    lr(1'b1, 4'h9, 64'h0);
    $display("t_fields done");
  endtask : t_fields

  task automatic t_access();
    hyp.low_entry_irq_on <= 1'b1;
    on_hyp <= 1'b0;
    acc(1'b1, EL_HYP, {CRM_LR_TOP, 1'b0}, 3'h3, 64'h1, 1'b1);
    on_hyp <= 1'b1;
    on_top <= 1'b0;
    acc(1'b0, EL_TOP, {CRM_LR_TOP, 1'b0}, 3'h3, 64'h0, 1'b1);
    check("trap rd", rd, 64'h0);
    on_top <= 1'b1;
    acc(1'b0, EL_TOP, {CRM_LR_TOP, 1'b0}, 3'h3, 64'h0, 1'b0);
    check("lr3", rd, 64'h0);
    acc(1'b1, EL_TOP, CRM_CTL, OP2_STATUS, '1, 1'b0);
    acc(1'b0, EL_HYP, CRM_CTL, OP2_STATUS, 64'h0, 1'b0);
    check("status rd", rd, 64'h2);
    acc(1'b0, EL_HYP, 4'h0, 3'h0, 64'h0, 1'b0);
    check("unmapped", rd, 64'h0);
    $display("t_access done");
  endtask : t_access

  task automatic t_flags();
    logic [1:0] v;
    hyp <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 5'h0};
    for (int i = 0; i < 4; i++)
    begin
      v = 2'(i);
      vm <= '{v[1], v[0]};
      settle();
      check("grp", status, {~v[1], v[1], ~v[0], v[0], 4'h0});
      check("irq", irq, 1'b1);
    end
    hyp <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 5'h0};
    settle();
    check("np", status, 64'h8);
    check("irq off", irq, 1'b0);
    hyp.unmatched_end_tally <= 5'h1;
    hyp.en <= 1'b1;
    settle();
    check("missing", status, 64'hc);
    check("irq on", irq, 1'b1);
    $display("t_flags done");
  endtask : t_flags

  task automatic t_life();
    hyp <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 5'h0};
    lr(1'b1, 4'h0, 64'ha000_0014_0000_0021);
    lr(1'b1, 4'h1, 64'h4000_0200_0000_0022);
    settle();
    check("two live", status, 64'h0);
    evt(1'b1, 4'h1);
    lr(1'b0, 4'h1, 64'h0);
    check("acked", rd, 64'h8000_0200_0000_0022);
    settle();
    check("no pend", status, 64'h8);
    evt(1'b0, 4'h0);
    check("dq", {dq.valid, dq.per_cpu_irq, dq.pe, dq.physical_int_id}, {2'b11, 8'h00, 10'd20});
    lr(1'b0, 4'h0, 64'h0);
    check("deact0", rd, 64'h2000_0014_0000_0021);
    settle();
    check("one live", status, 64'ha);
    evt(1'b0, 4'h1);
    check("no dq", dq.valid, 1'b0);
    settle();
    check("eoi", status, 64'hb);
    check("irq", irq, 1'b1);
    $display("t_life done");
  endtask : t_life

  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Cuts a hang short
  initial
  begin
    repeat (5000) @(posedge mclk);
    failures++;
    results();
  end

  // Main sequence
  initial
  begin
    failures = 0;
    n_compared = 0;
    rst_b = 1'b0;
    req = '0;
    hyp = '0;
    vm = '0;
    on_hyp = 1'b1;
    on_top = 1'b1;
    ack_evt = '0;
    deact_evt = '0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_fields();
    t_access();
    t_flags();
    t_life();
    results();
  end
endmodule : tb
